/* src/codec_ctrl_consts.svh */
`ifndef CODEC_CTRL_CONSTS_SVH
`define CODEC_CTRL_CONSTS_SVH
// ************************************************************
// register offsets
// ************************************************************
`define OFF_DAC3_R 7'h19
`define OFF_MASTER 7'h1C
`define OFF_ADC_CTL 7'h1D
`define OFF_TX_CTL 7'h1E
// ************************************************************
// field positions and reset values
// ************************************************************
`define BIT_UPDATE 8
`define ATTEN_RESET 8'hFF
`define ADC_RESET 9'h140
`define TX_RESET 7'h02
`define SRC_RECEIVER 2'h0
`endif

/* src/codec_ctrl_pkg.sv */
package codec_ctrl_pkg;
    typedef struct packed {
        logic reference_impedance_sel;
        logic [2:0] adc_clock_ratio;
        logic adc_highpass_off;
        logic adc_oversample_sel;
        logic adc_global_mute;
        logic adc_right_mute;
        logic adc_left_mute;
    } adc_ctl_s;
    typedef struct packed {
        logic validity_value_sub1;
        logic validity_value_sub0;
        logic validity_override_en;
        logic through_route;
        logic channel_bits_override;
        logic [1:0] tx_source_sel;
    } tx_ctl_s;
endpackage

/* src/validity_sel.sv */
`timescale 1ns/1ps
`include "codec_ctrl_consts.svh"
// picks the transmitted validity bit per subframe
module validity_sel (
    // control
    input wire codec_ctrl_pkg::tx_ctl_s ctl,
    // stream
    input wire logic rx_validity,
    input wire logic subframe,
    output logic validity
);
    // ************************************************************
    // selection
    // ************************************************************
    // override wins; else only receiver path passes validity
    always_comb begin
        if (ctl.validity_override_en) begin
            validity = subframe ? ctl.validity_value_sub1 : ctl.validity_value_sub0;
        end else if (ctl.tx_source_sel == `SRC_RECEIVER) begin
            validity = rx_validity;
        end else begin
            validity = 1'b0;
        end
    end
endmodule

/* src/codec_ctrl_regs.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "codec_ctrl_consts.svh"
// Behaviour
// - a dac3 right write with bit 8 clear only fills the staging latch; set applies all.
// - master attenuation is 8 bits in 0.5 dB steps and resets to all ones.
// - a master write with bit 8 clear stages; set applies all channels at once.
// - adc control bits 0,1,2 mute left, right and both, cleared at reset.
// - adc control bit 3 selects oversampling ratio, reset zero.
// - adc control bit 4 disables the high-pass filter, reset zero.
// - adc control bits 7:5 select the adc clock ratio, reset 010.
// - adc control bit 8 selects reference impedance, reset one.
// - tx control bits 1:0 select the transmitter source, reset 10.
// - tx bit 2 replaces channel bits only when the source is the receiver.
// - tx bit 3 routes the input mux straight to the output pin.
// - without override, validity is zero except receiver data, which passes.
// - with override, each subframe takes validity from its own bit.
// - subframe validity values sit at bits 5 and 6, reset zero.
// - dac3 right attenuation is 8 bits, reset all ones.
module codec_ctrl_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register port
    input wire logic [6:0] addr,
    input wire logic [8:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [8:0] rdata,
    // applied attenuation
    output logic [7:0] dac3_right_atten_value,
    output logic [7:0] master_atten_value,
    output logic atten_update,
    // adc controls
    output codec_ctrl_pkg::adc_ctl_s adc_ctl,
    // transmitter
    input wire logic rx_validity,
    input wire logic subframe,
    input wire logic tx_stream,
    input wire logic in_mux_stream,
    output codec_ctrl_pkg::tx_ctl_s tx_ctl,
    output logic use_status_regs,
    output logic tx_validity,
    output logic spdif_out_pin
);
    typedef struct packed {
        logic [7:0] stage_dac3;
        logic [7:0] stage_master;
        logic [7:0] dac3;
        logic [7:0] master;
        logic upd;
        codec_ctrl_pkg::adc_ctl_s adc;
        codec_ctrl_pkg::tx_ctl_s tx;
        logic [8:0] rdata;
        logic use_cs;
        logic val;
        logic pin;
    } state_s;

    state_s st;
    state_s next_st;
    logic val_c;

    // ************************************************************
    // validity selection
    // ************************************************************
    validity_sel u_val (
        .ctl(st.tx),
        .rx_validity(rx_validity),
        .subframe(subframe),
        .validity(val_c)
    );

    // ************************************************************
    // next state
    // ************************************************************
    // staging latches hold pending gains until an update strobe
    always_comb begin
        next_st = st;
        next_st.upd = 1'b0;
        next_st.rdata = 9'h000;
        if (wr) begin
            unique case (addr)
                `OFF_DAC3_R: begin
                    next_st.stage_dac3 = wdata[7:0];
                end
                `OFF_MASTER: begin
                    next_st.stage_master = wdata[7:0];
                end
                `OFF_ADC_CTL: begin
                    next_st.adc = wdata;
                end
                `OFF_TX_CTL: begin
                    next_st.tx = wdata[6:0];
                end
                default: begin
                end
            endcase
            // the strobe itself is not stored, so it reads back as zero
            if ((addr == `OFF_DAC3_R || addr == `OFF_MASTER) && wdata[`BIT_UPDATE]) begin
                next_st.dac3 = (addr == `OFF_DAC3_R) ? wdata[7:0] : st.stage_dac3;
                next_st.master = (addr == `OFF_MASTER) ? wdata[7:0] : st.stage_master;
                next_st.upd = 1'b1;
            end
        end
        if (rd) begin
            unique case (addr)
                `OFF_DAC3_R: next_st.rdata = {1'b0, st.stage_dac3};
                `OFF_MASTER: next_st.rdata = {1'b0, st.stage_master};
                `OFF_ADC_CTL: next_st.rdata = st.adc;
                `OFF_TX_CTL: next_st.rdata = {2'b00, st.tx};
                default: next_st.rdata = 9'h000;
            endcase
        end
        // channel overwrite only meaningful on the receiver through path
        next_st.use_cs = st.tx.channel_bits_override
                         && (st.tx.tx_source_sel == `SRC_RECEIVER);
        next_st.val = val_c;
        // one-cycle registered mux: pin lags its source by one mclk
        next_st.pin = st.tx.through_route ? in_mux_stream : tx_stream;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st.stage_dac3 <= `ATTEN_RESET;
            st.stage_master <= `ATTEN_RESET;
            st.dac3 <= `ATTEN_RESET;
            st.master <= `ATTEN_RESET;
            st.upd <= 1'b0;
            st.adc <= `ADC_RESET;
            st.tx <= `TX_RESET;
            st.rdata <= 9'h000;
            st.use_cs <= 1'b0;
            st.val <= 1'b0;
            st.pin <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata = st.rdata;
    assign dac3_right_atten_value = st.dac3;
    assign master_atten_value = st.master;
    assign atten_update = st.upd;
    assign adc_ctl = st.adc;
    assign tx_ctl = st.tx;
    assign use_status_regs = st.use_cs;
    assign tx_validity = st.val;
    assign spdif_out_pin = st.pin;

    // ************************************************************
    // checks
    // ************************************************************
    // ************************************************************
    // attenuation checks
    // ************************************************************
    // a staged dac3 write must leave the applied value alone
    a_stage_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_DAC3_R && !wdata[`BIT_UPDATE]) |=> $stable(dac3_right_atten_value))
        else $error("staged dac3 write changed output");
    // a dac3 strobe applies its own data and pulses the update
    a_dac3_apply: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_DAC3_R && wdata[`BIT_UPDATE])
        |=> (dac3_right_atten_value == $past(wdata[7:0])) && atten_update)
        else $error("dac3 update not applied");
    // a master strobe applies its own data
    a_master_apply: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_MASTER && wdata[`BIT_UPDATE])
        |=> master_atten_value == $past(wdata[7:0]))
        else $error("master update not applied");
    // a staged master write must leave the applied gain alone
    a_master_stage: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_MASTER && !wdata[`BIT_UPDATE]) |=> $stable(master_atten_value))
        else $error("staged master write changed output");
    // a dac3 strobe also releases the pending master gain
    a_master_cross: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_DAC3_R && wdata[`BIT_UPDATE])
        |=> master_atten_value == $past(st.stage_master))
        else $error("dac3 strobe did not apply master");
    // a master strobe also releases the pending dac3 value
    a_dac3_cross: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_MASTER && wdata[`BIT_UPDATE])
        |=> dac3_right_atten_value == $past(st.stage_dac3))
        else $error("master strobe did not apply dac3");
    // any strobe write raises the update pulse
    a_upd_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && (addr == `OFF_DAC3_R || addr == `OFF_MASTER) && wdata[`BIT_UPDATE])
        |=> atten_update)
        else $error("update pulse missing");
    // no strobe, no update pulse
    a_upd_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
        !(wr && (addr == `OFF_DAC3_R || addr == `OFF_MASTER) && wdata[`BIT_UPDATE])
        |=> !atten_update)
        else $error("spurious update pulse");
    // applied master gain only moves on a write
    a_master_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        !wr
        |=> $stable(master_atten_value))
        else $error("master gain moved without write");
    // applied dac3 value only moves on a write
    a_dac3_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        !wr
        |=> $stable(dac3_right_atten_value))
        else $error("dac3 value moved without write");
    // the dac3 latch takes the data of every dac3 write
    a_stage_dac3: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_DAC3_R)
        |=> st.stage_dac3 == $past(wdata[7:0]))
        else $error("dac3 latch not written");
    // the master latch takes the data of every master write
    a_stage_master: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_MASTER)
        |=> st.stage_master == $past(wdata[7:0]))
        else $error("master latch not written");
    // foreign writes never disturb the latches
    a_stage_foreign: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr != `OFF_DAC3_R && addr != `OFF_MASTER)
        |=> $stable(st.stage_dac3) && $stable(st.stage_master))
        else $error("latch hit by foreign write");

    // ************************************************************
    // register port checks
    // ************************************************************
    // dac3 read returns the latch with the strobe bit clear
    a_dac3_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && addr == `OFF_DAC3_R)
        |=> rdata == {1'b0, $past(st.stage_dac3)})
        else $error("dac3 read wrong");
    // the dac3 strobe bit is never kept
    a_dac3_unkept: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && addr == `OFF_DAC3_R)
        |=> !rdata[`BIT_UPDATE])
        else $error("dac3 strobe kept");
    // master read returns the latch with the strobe bit clear
    a_master_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && addr == `OFF_MASTER)
        |=> rdata == {1'b0, $past(st.stage_master)})
        else $error("master read wrong");
    // the master strobe bit is never kept
    a_master_unkept: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && addr == `OFF_MASTER)
        |=> !rdata[`BIT_UPDATE])
        else $error("master strobe kept");
    // adc control reads back whole
    a_adc_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && addr == `OFF_ADC_CTL)
        |=> rdata == $past(adc_ctl))
        else $error("adc read wrong");
    // tx control reads back with the two spare bits clear
    a_tx_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (rd && addr == `OFF_TX_CTL)
        |=> rdata == {2'b00, $past(tx_ctl)})
        else $error("tx read wrong");
    // read data stand for one cycle only
    a_rdata_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        !rd
        |=> rdata == 9'h000)
        else $error("read data outside read slot");
    // adc control takes the whole write word
    a_adc_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_ADC_CTL)
        |=> adc_ctl == $past(wdata))
        else $error("adc control not written");
    // adc control ignores writes to other offsets
    a_other_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr != `OFF_ADC_CTL)
        |=> $stable(adc_ctl))
        else $error("adc control hit by foreign write");
    // adc control holds without writes
    a_adc_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        !wr
        |=> $stable(adc_ctl))
        else $error("adc control moved without write");
    // tx control takes the low seven bits of the write
    a_tx_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr == `OFF_TX_CTL)
        |=> tx_ctl == $past(wdata[6:0]))
        else $error("tx control not written");
    // tx control ignores writes to other offsets
    a_tx_foreign: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && addr != `OFF_TX_CTL)
        |=> $stable(tx_ctl))
        else $error("tx control hit by foreign write");
    // tx control holds without writes
    a_tx_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        !wr
        |=> $stable(tx_ctl))
        else $error("tx control moved without write");

    // ************************************************************
    // transmitter checks
    // ************************************************************
    // without override, non-receiver sources send validity zero
    a_valid_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        (!tx_ctl.validity_override_en && tx_ctl.tx_source_sel != `SRC_RECEIVER)
        |=> !tx_validity)
        else $error("validity not zero");
    // without override, the receiver source passes its validity
    a_valid_rx: assert property (@(posedge mclk) disable iff (!arst_n)
        (!tx_ctl.validity_override_en && tx_ctl.tx_source_sel == `SRC_RECEIVER)
        |=> tx_validity == $past(rx_validity))
        else $error("receiver validity not passed");
    // with override, subframe 1 takes its own bit
    a_valid_ovr: assert property (@(posedge mclk) disable iff (!arst_n)
        (tx_ctl.validity_override_en && subframe)
        |=> tx_validity == $past(tx_ctl.validity_value_sub1))
        else $error("subframe 1 validity wrong");
    // with override, subframe 0 takes its own bit
    a_valid_sub0: assert property (@(posedge mclk) disable iff (!arst_n)
        (tx_ctl.validity_override_en && !subframe)
        |=> tx_validity == $past(tx_ctl.validity_value_sub0))
        else $error("subframe 0 validity wrong");
    // through mode drives the pin from the input mux
    a_pin_route: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_ctl.through_route
        |=> spdif_out_pin == $past(in_mux_stream))
        else $error("through route wrong");
    // normal mode drives the pin from the transmitter
    a_pin_tx: assert property (@(posedge mclk) disable iff (!arst_n)
        !tx_ctl.through_route
        |=> spdif_out_pin == $past(tx_stream))
        else $error("transmitter route wrong");
    // channel overwrite is ignored for non-receiver sources
    a_cs_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        (tx_ctl.tx_source_sel != `SRC_RECEIVER)
        |=> !use_status_regs)
        else $error("channel overwrite outside receiver source");
    // channel overwrite takes effect on the receiver source
    a_cs_on: assert property (@(posedge mclk) disable iff (!arst_n)
        (tx_ctl.channel_bits_override && tx_ctl.tx_source_sel == `SRC_RECEIVER)
        |=> use_status_regs)
        else $error("channel overwrite not applied");
    // without the overwrite bit the recovered bits pass
    a_cs_off: assert property (@(posedge mclk) disable iff (!arst_n)
        !tx_ctl.channel_bits_override
        |=> !use_status_regs)
        else $error("channel overwrite without its bit");
endmodule

/* testbench/codec_ctrl_regs_tb.sv */
`timescale 1ns/1ps
module codec_ctrl_regs_tb;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [8:0] wdata = 9'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rx_validity = 1'b0;
    logic subframe = 1'b0;
    logic tx_stream = 1'b0;
    logic in_mux_stream = 1'b0;
    logic [8:0] rdata;
    logic [7:0] dac3_right_atten_value;
    logic [7:0] master_atten_value;
    logic atten_update;
    logic use_status_regs;
    logic tx_validity;
    logic spdif_out_pin;
    codec_ctrl_pkg::adc_ctl_s adc_ctl;
    codec_ctrl_pkg::tx_ctl_s tx_ctl;
    int err_count = 0;
    int n_tests = 0;

    codec_ctrl_regs i_codec_ctrl_regs (.mclk(mclk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .dac3_right_atten_value(dac3_right_atten_value),
        .master_atten_value(master_atten_value), .atten_update(atten_update),
        .adc_ctl(adc_ctl), .rx_validity(rx_validity), .subframe(subframe),
        .tx_stream(tx_stream), .in_mux_stream(in_mux_stream), .tx_ctl(tx_ctl),
        .use_status_regs(use_status_regs), .tx_validity(tx_validity),
        .spdif_out_pin(spdif_out_pin));

    // 200 MHz system clock
    always #2.5 mclk = ~mclk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write; effects are looked at 1 ns after the taking edge
    task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp, input string what);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // inputs change at an edge, the registered paths answer one edge later
    task automatic set_in(input logic v, input logic s, input logic t, input logic m);
        @(posedge mclk);
        rx_validity <= v;
        subframe <= s;
        tx_stream <= t;
        in_mux_stream <= m;
        @(posedge mclk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        chk("dac3 out", 9'h0FF, dac3_right_atten_value);
        chk("master out", 9'h0FF, master_atten_value);
        chk("adc ctl", 9'h140, adc_ctl);
        chk("tx ctl", 9'h002, tx_ctl);
        rd_chk(7'h1D, 9'h140, "adc read");
        rd_chk(7'h1E, 9'h002, "tx read");
    endtask

    // staged values must not reach the outputs until a strobe write
    task automatic t_atten();
        wr_reg(7'h19, 9'h033);
        chk("dac3 staged", 9'h0FF, dac3_right_atten_value);
        chk("no update", 9'h000, atten_update);
        wr_reg(7'h1C, 9'h180);
        chk("master applied", 9'h080, master_atten_value);
        chk("dac3 applied", 9'h033, dac3_right_atten_value);
        chk("update pulse", 9'h001, atten_update);
        @(posedge mclk);
        #1;
        chk("pulse ends", 9'h000, atten_update);
        rd_chk(7'h1C, 9'h080, "strobe not kept");
        wr_reg(7'h1C, 9'h011);
        chk("master staged", 9'h080, master_atten_value);
        rd_chk(7'h1C, 9'h011, "master stage read");
        wr_reg(7'h19, 9'h100);
        chk("dac3 strobe", 9'h000, dac3_right_atten_value);
        chk("master follows", 9'h011, master_atten_value);
        rd_chk(7'h19, 9'h000, "dac3 read");
    endtask

    // clock ratio codes 0 to 6, with the low five adc bits set, then one stray write
    task automatic t_adc();
        for (int i = 0; i < 7; i++) begin
            wr_reg(7'h1D, {1'b0, 3'(i), 5'h1F});
            chk("adc ctl", {1'b0, 3'(i), 5'h1F}, adc_ctl);
        end
        wr_reg(7'h10, 9'h1FF);
        rd_chk(7'h10, 9'h000, "unmapped read");
        chk("adc kept", 9'h0DF, adc_ctl);
        chk("tx kept", 9'h002, tx_ctl);
        chk("master kept", 9'h011, master_atten_value);
    endtask

    task automatic t_tx();
        for (int i = 0; i < 4; i++) begin
            wr_reg(7'h1E, {7'h01, 2'(i)});
            set_in(1'b1, 1'b0, 1'b0, 1'b0);
            chk("status regs", {8'h00, i == 0}, use_status_regs);
            chk("validity", {8'h00, i == 0}, tx_validity);
        end
        wr_reg(7'h1E, 9'h050);
        set_in(1'b1, 1'b0, 1'b0, 1'b0);
        chk("sub0 validity", 9'h000, tx_validity);
        set_in(1'b0, 1'b1, 1'b0, 1'b0);
        chk("sub1 validity", 9'h001, tx_validity);
        rd_chk(7'h1E, 9'h050, "tx read");
        wr_reg(7'h1E, 9'h008);
        set_in(1'b0, 1'b0, 1'b0, 1'b1);
        chk("through pin", 9'h001, spdif_out_pin);
        wr_reg(7'h1E, 9'h000);
        set_in(1'b0, 1'b0, 1'b1, 1'b0);
        chk("tx pin", 9'h001, spdif_out_pin);
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1;
        t_reset();
        t_atten();
        t_adc();
        t_tx();
        report_and_stop();
    end

    // the tests need under a hundred cycles; a hang ends well beyond that
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end
endmodule
